// >>> pkg/exec_pkg.sv
// Constants for the clear/kick/invert instruction execution block
// What this block does
// - A watchdog kick loads zero into the watchdog counter, restarting its interval.
// - A watchdog kick clears the watchdog postscaler to zero in the same execution.
// - A watchdog kick sets both the timeout flag and the sleep flag to one.
// - An invert instruction produces the bitwise complement of the addressed byte.
// - With destination bit zero the inverted byte goes to the accumulator, memory untouched.
// - With destination bit one the inverted byte is written back to the addressed byte.
// - With access bit zero the operand sits in the access bank, bank pointer ignored.
// - With access bit one the operand bank comes from the bank pointer.
// - A zero-register instruction writes zero to the addressed byte and sets the null flag.
package exec_pkg;
    localparam logic [15:0] KICK_WORD      = 16'h0004;
    localparam logic [6:0]  ZERO_OPC       = 7'h35;
    localparam logic [5:0]  INVERT_OPC     = 6'h07;
    localparam int          ACCESS_BIT     = 8;
    localparam int          DEST_BIT       = 9;
    localparam logic [3:0]  ACCESS_BANK_LO = 4'h0;
    localparam logic [3:0]  ACCESS_BANK_HI = 4'hF;
    localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;
    localparam logic [7:0]  ZERO_BYTE      = 8'h00;
    localparam int          PHASES         = 4;
    typedef enum logic [1:0] {
        PH_DECODE  = 2'b00,
        PH_READ    = 2'b01,
        PH_PROCESS = 2'b10,
        PH_WRITE   = 2'b11
    } phase_t;
    typedef enum logic [1:0] {
        OP_NONE   = 2'b00,
        OP_KICK   = 2'b01,
        OP_ZERO   = 2'b10,
        OP_INVERT = 2'b11
    } op_t;
endpackage

// >>> verilog/addr_resolve.sv
// Operand bank resolution from access bit and bank pointer
module addr_resolve
    import exec_pkg::*;
(
    input  wire logic [7:0]  i_file,
    input  wire logic        i_access,
    input  wire logic [3:0]  i_bank_pointer,
    output logic      [11:0] o_addr
);
    always_comb begin
        if (i_access) begin
            o_addr = {i_bank_pointer, i_file};
        end else if (i_file < ACCESS_SPLIT) begin
            o_addr = {ACCESS_BANK_LO, i_file};
        end else begin
            o_addr = {ACCESS_BANK_HI, i_file};
        end
    end
endmodule

// >>> verilog/insn_exec.sv
// Four-phase execution of watchdog kick, zero-register and invert-register
module insn_exec
    import exec_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_insn_valid,
    input  wire logic [15:0] i_insn,
    input  wire logic [3:0]  i_bank_pointer,
    input  wire logic [7:0]  i_mem_rdata,
    output logic             o_busy,
    output logic [11:0]      o_mem_addr,
    output logic             o_mem_rd,
    output logic             o_mem_we,
    output logic [7:0]       o_mem_wdata,
    output logic             o_acc_we,
    output logic [7:0]       o_acc_wdata,
    output logic             o_wdt_clear,
    output logic             o_post_clear,
    output logic             o_timeout_flag,
    output logic             o_sleep_flag,
    output logic             o_flag_we,
    output logic             o_null_flag,
    output logic             o_msb_flag
);
    phase_t      phase_q;
    op_t         op_q;
    op_t         op_d;
    logic [15:0] insn_q;
    logic [7:0]  result_q;
    logic [11:0] addr_w;

    // Unknown words are taken but act as no-ops so the phase walk stays regular
    always_comb begin
        op_d = OP_NONE;
        if (i_insn == KICK_WORD) begin
            op_d = OP_KICK;
        end else if (i_insn[15:9] == ZERO_OPC) begin
            op_d = OP_ZERO;
        end else if (i_insn[15:10] == INVERT_OPC) begin
            op_d = OP_INVERT;
        end
    end

    addr_resolve u_addr (
        .i_file         (insn_q[7:0]),
        .i_access       (insn_q[ACCESS_BIT]),
        .i_bank_pointer (i_bank_pointer),
        .o_addr         (addr_w)
    );

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            phase_q <= PH_DECODE;
            op_q    <= OP_NONE;
            insn_q  <= 16'h0000;
            o_busy  <= 1'b0;
        end else begin
            unique case (phase_q)
                PH_DECODE: begin
                    if (i_insn_valid) begin
                        phase_q <= PH_READ;
                        op_q    <= op_d;
                        insn_q  <= i_insn;
                        o_busy  <= 1'b1;
                    end
                end
                PH_READ:    phase_q <= PH_PROCESS;
                PH_PROCESS: phase_q <= PH_WRITE;
                PH_WRITE: begin
                    phase_q <= PH_DECODE;
                    o_busy  <= 1'b0;
                end
            endcase
        end
    end

    // Memory address and read strobe in the read phase
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_mem_addr <= 12'h000;
            o_mem_rd   <= 1'b0;
        end else begin
            if (phase_q == PH_DECODE && i_insn_valid) begin
                o_mem_addr <= 12'h000;
            end else if (phase_q == PH_READ) begin
                o_mem_addr <= addr_w;
            end
            o_mem_rd <= (phase_q == PH_READ) && (op_q == OP_INVERT);
        end
    end

    // Result computed in the process phase from the byte returned by memory
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            result_q <= ZERO_BYTE;
        end else if (phase_q == PH_PROCESS) begin
            if (op_q == OP_INVERT) begin
                result_q <= ~i_mem_rdata;
            end else begin
                result_q <= ZERO_BYTE;
            end
        end
    end

    // Destination writes land in the write phase as one-cycle pulses
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_mem_we    <= 1'b0;
            o_mem_wdata <= ZERO_BYTE;
            o_acc_we    <= 1'b0;
            o_acc_wdata <= ZERO_BYTE;
            o_flag_we   <= 1'b0;
            o_null_flag <= 1'b0;
            o_msb_flag  <= 1'b0;
        end else begin
            o_mem_we  <= 1'b0;
            o_acc_we  <= 1'b0;
            o_flag_we <= 1'b0;
            if (phase_q == PH_WRITE) begin
                if (op_q == OP_ZERO) begin
                    o_mem_we    <= 1'b1;
                    o_mem_wdata <= ZERO_BYTE;
                    o_flag_we   <= 1'b1;
                    o_null_flag <= 1'b1;
                    o_msb_flag  <= 1'b0;
                end else if (op_q == OP_INVERT) begin
                    o_mem_we    <= insn_q[DEST_BIT];
                    o_acc_we    <= !insn_q[DEST_BIT];
                    o_mem_wdata <= result_q;
                    o_acc_wdata <= result_q;
                    o_flag_we   <= 1'b1;
                    o_null_flag <= (result_q == ZERO_BYTE);
                    o_msb_flag  <= result_q[7];
                end
            end
        end
    end

    // Watchdog kick acts in the process phase
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_wdt_clear    <= 1'b0;
            o_post_clear   <= 1'b0;
            o_timeout_flag <= 1'b0;
            o_sleep_flag   <= 1'b0;
        end else begin
            o_wdt_clear  <= (phase_q == PH_PROCESS) && (op_q == OP_KICK);
            o_post_clear <= (phase_q == PH_PROCESS) && (op_q == OP_KICK);
            if (phase_q == PH_PROCESS && op_q == OP_KICK) begin
                o_timeout_flag <= 1'b1;
                o_sleep_flag   <= 1'b1;
            end
        end
    end

    sequence kick_taken_s;
        phase_q == PH_DECODE && i_insn_valid && i_insn == KICK_WORD;
    endsequence

    sequence kick_done_s;
        o_wdt_clear && o_post_clear && o_timeout_flag && o_sleep_flag;
    endsequence

    kick_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        kick_taken_s |-> ##3 kick_done_s)
        else $error("kick did not clear watchdog");
    post_pair_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_wdt_clear == o_post_clear)
        else $error("postscaler clear not with counter clear");
    kick_flags_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_wdt_clear |-> o_timeout_flag && o_sleep_flag)
        else $error("kick flags not set");
    invert_value_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (phase_q == PH_PROCESS && op_q == OP_INVERT) |=> result_q == ~$past(i_mem_rdata))
        else $error("invert result wrong");
    dest_acc_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (phase_q == PH_WRITE && op_q == OP_INVERT && !insn_q[DEST_BIT])
        |=> o_acc_we && !o_mem_we && o_acc_wdata == $past(result_q))
        else $error("invert to accumulator wrong");
    dest_mem_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (phase_q == PH_WRITE && op_q == OP_INVERT && insn_q[DEST_BIT])
        |=> o_mem_we && !o_acc_we && o_mem_wdata == $past(result_q))
        else $error("invert writeback wrong");
    access_bank_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (phase_q == PH_READ && !insn_q[ACCESS_BIT])
        |=> o_mem_addr[11:8] == (insn_q[7] ? ACCESS_BANK_HI : ACCESS_BANK_LO))
        else $error("access bank address wrong");
    bank_ptr_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (phase_q == PH_READ && insn_q[ACCESS_BIT])
        |=> o_mem_addr[11:8] == $past(i_bank_pointer))
        else $error("bank pointer not used");
    zero_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (phase_q == PH_WRITE && op_q == OP_ZERO)
        |=> o_mem_we && o_mem_wdata == ZERO_BYTE && o_null_flag)
        else $error("zero register wrong");
    invert_flags_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (phase_q == PH_WRITE && op_q == OP_INVERT)
        |=> o_msb_flag == o_mem_wdata[7] && o_null_flag == (o_mem_wdata == ZERO_BYTE))
        else $error("invert flags wrong");

    // Helper count of busy cycles; a stuck phase walk would run it past the span
    logic [1:0] span_q;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            span_q <= 2'b00;
        end else if (o_busy) begin
            span_q <= span_q + 2'b01;
        end else begin
            span_q <= 2'b00;
        end
    end

    busy_span_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_busy |-> span_q < 2'(PHASES - 1))
        else $error("busy outlasts the phase walk");
    read_strobe_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (phase_q == PH_READ) |=> o_mem_rd == (op_q == OP_INVERT))
        else $error("read strobe wrong");
    read_pulse_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_mem_rd |=> !o_mem_rd)
        else $error("read strobe longer than one cycle");
    flag_rise_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(o_timeout_flag) || $rose(o_sleep_flag) |-> o_wdt_clear)
        else $error("status flags set without kick");
endmodule

// >>> tb/watchdog_clear_complement_exec_test.sv
// Self-checking bench for the kick, zero-register and invert-register execution block
module watchdog_clear_complement_exec_test
    import exec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        i_clk = 1'b0;
    logic        i_resetn = 1'b0;
    logic        i_insn_valid = 1'b0;
    logic [15:0] i_insn = 16'h0000;
    logic [3:0]  i_bank_pointer = 4'h0;
    logic [7:0]  i_mem_rdata = 8'h00;
    logic        o_busy, o_mem_rd, o_mem_we, o_acc_we, o_wdt_clear, o_post_clear;
    logic        o_timeout_flag, o_sleep_flag, o_flag_we, o_null_flag, o_msb_flag;
    logic [11:0] o_mem_addr;
    logic [7:0]  o_mem_wdata, o_acc_wdata;
    logic [11:0] n_rd, n_we, n_acc, n_wdt, n_post, n_flag, a_rd, a_we;
    logic [7:0]  wd, ad;
    logic        nul, msb;
    int          failures = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    insn_exec dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_insn_valid(i_insn_valid),
        .i_insn(i_insn), .i_bank_pointer(i_bank_pointer), .i_mem_rdata(i_mem_rdata),
        .o_busy(o_busy), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_we(o_mem_we),
        .o_mem_wdata(o_mem_wdata), .o_acc_we(o_acc_we), .o_acc_wdata(o_acc_wdata),
        .o_wdt_clear(o_wdt_clear), .o_post_clear(o_post_clear),
        .o_timeout_flag(o_timeout_flag), .o_sleep_flag(o_sleep_flag), .o_flag_we(o_flag_we),
        .o_null_flag(o_null_flag), .o_msb_flag(o_msb_flag));

    always #4 i_clk = ~i_clk;

    // Hang guard: seven short instructions need well under two hundred cycles
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures = failures + 1;
            stop_test();
        end
    end

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("[FAIL] %0d ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Offers one word, then tallies every pulse over the whole execution window
    task automatic run(input logic [15:0] insn, input logic [3:0] bp, input logic [7:0] rd);
        int k;
        {n_rd, n_we, n_acc, n_wdt, n_post, n_flag} = '0;
        // Unknown captures so a missing pulse cannot reuse an earlier run's value
        {a_rd, a_we, wd, ad, nul, msb} = 'x;
        @(negedge i_clk);
        i_insn_valid = 1'b1;
        i_insn = insn;
        i_bank_pointer = bp;
        i_mem_rdata = rd;
        @(posedge i_clk);
        @(negedge i_clk);
        i_insn_valid = 1'b0;
        for (k = 0; k < 6; k++) begin
            if (o_mem_rd === 1'b1) begin n_rd++; a_rd = o_mem_addr; end
            if (o_mem_we === 1'b1) begin n_we++; a_we = o_mem_addr; wd = o_mem_wdata; end
            if (o_acc_we === 1'b1) begin n_acc++; ad = o_acc_wdata; end
            if (o_wdt_clear === 1'b1) n_wdt++;
            if (o_post_clear === 1'b1) n_post++;
            if (o_flag_we === 1'b1) begin n_flag++; nul = o_null_flag; msb = o_msb_flag; end
            @(negedge i_clk);
        end
        k = 0;
        while (o_busy !== 1'b0 && k < 20) begin @(negedge i_clk); k++; end
        check(12'(o_busy), 12'h000);
    endtask

    task automatic test_kick();
        check(12'({o_timeout_flag, o_sleep_flag}), 12'h000);
        run(KICK_WORD, 4'h6, 8'h5A);
        check(n_wdt, 12'h001);
        check(n_post, 12'h001);
        check(12'({o_timeout_flag, o_sleep_flag}), 12'h003);
        check(n_we + n_acc, 12'h000);
    endtask

    task automatic test_zero(input logic a, input logic [7:0] f, input logic [11:0] ea);
        run({ZERO_OPC, a, f}, 4'h3, 8'hA5);
        check(n_we, 12'h001);
        check(12'(wd), 12'h000);
        check(a_we, ea);
        check(n_flag, 12'h001);
        check(12'({nul, msb}), 12'h002);
        check(n_rd + n_acc, 12'h000);
    endtask

    // Destination, bank source and flag outcome all vary across the calls
    task automatic test_invert(input logic d, input logic a, input logic [7:0] f,
                               input logic [3:0] bp, input logic [7:0] rd,
                               input logic [11:0] ea);
        run({INVERT_OPC, d, a, f}, bp, rd);
        check(n_rd, 12'h001);
        check(a_rd, ea);
        check(n_we, 12'(d));
        check(n_acc, 12'(!d));
        if (d) check(12'(wd), {4'h0, ~rd});
        else check(12'(ad), {4'h0, ~rd});
        if (d) check(a_we, ea);
        check(n_flag, 12'h001);
        check(12'({nul, msb}), 12'({rd == 8'hFF, ~rd[7]}));
    endtask

    task automatic test_unknown();
        run(16'hFFFF, 4'h1, 8'h33);
        check(n_rd + n_we + n_acc + n_wdt + n_post + n_flag, 12'h000);
    endtask

    initial begin
        repeat (10) @(negedge i_clk);
        i_resetn = 1'b1;
        test_kick();
        test_zero(1'b0, 8'h25, 12'h025);
        test_zero(1'b1, 8'h80, 12'h380);
        test_invert(1'b1, 1'b1, 8'h90, 4'hA, 8'h13, 12'hA90);
        test_invert(1'b0, 1'b0, 8'hC3, 4'h7, 8'hFF, 12'hFC3);
        test_invert(1'b0, 1'b0, 8'h7F, 4'h2, 8'h80, 12'h07F);
        test_unknown();
        stop_test();
    end
endmodule
